// ---- rtl/mfsq_pkg.sv ----
// Shared constants, types and helpers of the multiframe S and Q channel block.
`default_nettype none
package mfsq_pkg;

   // Multiframe geometry.
   localparam logic [4:0] FRAME_NONE  = 5'h00;
   localparam logic [4:0] FRAME_FIRST = 5'h01;
   localparam logic [4:0] FRAME_LAST  = 5'h14;
   localparam logic [4:0] SLOT_LEN    = 5'h05;
   localparam logic [2:0] SLOT_FIRST  = 3'h0;
   localparam logic [2:0] SLOT_LAST   = 3'h4;
   localparam logic [1:0] GROUP_FIRST = 2'h0;
   localparam logic [1:0] GROUP_LAST  = 2'h3;

   // Three multiframes in a row win or lose alignment.
   localparam logic [1:0] GOOD_LAST   = 2'h2;
   localparam logic [1:0] BAD_LAST    = 2'h2;

   // Line interface activation states that allow alignment.
   localparam logic [2:0] LINE_F6     = 3'h4;
   localparam logic [2:0] LINE_F7     = 3'h5;

   // Field positions of multiframe_status_buffer.
   localparam int ST_COS    = 7;
   localparam int ST_QEMPTY = 6;
   localparam int ST_AVAIL  = 5;
   // Position of the hunting value in q_bit_buffer.
   localparam int QB_HUNT   = 4;

   // Reset values.
   localparam logic [4:0] QBUF_RST   = 5'h00;
   localparam logic [4:0] SWORD_RST  = 5'h00;
   localparam logic       QEMPTY_RST = 1'b1;

   // Word buffer between the S assembler and the status buffer.
   localparam int SWORD_W    = 6;
   localparam int FIFO_DEPTH = 16;

   // Read deadline that software must meet after the available flag.
   localparam int DEADLINE_US     = 1250;
   localparam int CLK_MHZ         = 25;
   localparam int DEADLINE_CYCLES = DEADLINE_US * CLK_MHZ;

   typedef enum logic [0:0] {MFSQ_HUNT, MFSQ_SYNC} mfsq_sync_e;

   // Overhead bits of one received line frame.
   typedef struct packed {
      logic fa;
      logic m;
      logic s;
   } mfsq_frame_s;

   // One compiled S word and its position marker.
   typedef struct packed {
      logic       first;
      logic [4:0] word;
   } mfsq_sword_s;

   // Position of a frame inside its five-frame group.
   function automatic logic [2:0] mfsq_slot(input logic [4:0] f);
      logic [4:0] z;
      z = f - FRAME_FIRST;
      return 3'(z % SLOT_LEN);
   endfunction : mfsq_slot

   // Index of the five-frame group that holds a frame.
   function automatic logic [1:0] mfsq_group(input logic [4:0] f);
      logic [4:0] z;
      z = f - FRAME_FIRST;
      return 2'(z / SLOT_LEN);
   endfunction : mfsq_group

endpackage : mfsq_pkg
`default_nettype wire

// ---- rtl/mfsq_fifo.sv ----
// Parameterised word FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module mfsq_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             full;
   logic             empty;

   // The extra pointer bit tells a full buffer from an empty one.
   assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty     = (wr_q == rd_q);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[rd_q[AW-1:0]];

   // Storage needs no reset; only the pointers carry control state.
   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointer advance on each accepted handshake.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : mfsq_fifo
`default_nettype wire

// ---- rtl/mfsq_frame_track.sv ----
// Frame counter and per-multiframe alignment check on received overhead bits.
`timescale 1ns/100ps
`default_nettype none
module mfsq_frame_track (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  hunt_en,
   input  wire logic                  strobe,
   input  wire mfsq_pkg::mfsq_frame_s rx,
   output logic                 [4:0] frame_nxt,
   output logic                       mf_done,
   output logic                       mf_valid
);
   logic [4:0] cnt_q;
   logic       err_q;
   logic       exp_fa;
   logic       bad;

   // An M bit of one restarts the count; zero means no alignment yet.
   always_comb begin
      if (rx.m) begin
         frame_nxt = mfsq_pkg::FRAME_FIRST;
      end else if (cnt_q == mfsq_pkg::FRAME_NONE) begin
         frame_nxt = mfsq_pkg::FRAME_NONE;
      end else if (cnt_q == mfsq_pkg::FRAME_LAST) begin
         frame_nxt = mfsq_pkg::FRAME_FIRST;
      end else begin
         frame_nxt = cnt_q + 5'h01;
      end
   end

   // Expected pattern: FA high at the head of each group, M only in frame one.
   assign exp_fa   = (frame_nxt != mfsq_pkg::FRAME_NONE) &&
                     (mfsq_pkg::mfsq_slot(frame_nxt) == mfsq_pkg::SLOT_FIRST);
   assign bad      = (rx.fa != exp_fa) || (rx.m != (frame_nxt == mfsq_pkg::FRAME_FIRST));
   assign mf_done  = strobe && hunt_en && (cnt_q != mfsq_pkg::FRAME_NONE) &&
                     (frame_nxt == mfsq_pkg::FRAME_FIRST);
   assign mf_valid = mf_done && !err_q && rx.m && (cnt_q == mfsq_pkg::FRAME_LAST);

   // Counter and error history are cleared whenever hunting is not allowed.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= mfsq_pkg::FRAME_NONE;
         err_q <= 1'b0;
      end else if (!hunt_en) begin
         cnt_q <= mfsq_pkg::FRAME_NONE;
         err_q <= 1'b0;
      end else if (strobe) begin
         cnt_q <= frame_nxt;
         err_q <= (frame_nxt == mfsq_pkg::FRAME_FIRST) ? bad : (err_q || bad);
      end
   end
endmodule : mfsq_frame_track
`default_nettype wire

// ---- rtl/mfsq_top.sv ----
// Multiframe alignment, S word reception and Q bit insertion for the line interface.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Deliver four five-bit S words per multiframe.
// - Set available flag when five aligned S bits load.
// - Twenty S bits form five idle-zero subchannels.
// - Enhanced mode interrupts only on non-zero words.
// - Non-zero word clears enhanced enable when interrupts on.
// - Mark the first word of each multiframe.
// - Q bits in frames 1/6/11/16, else zero.
// - Q-empty set at reset and transfer, read clears.
// - Aligned: send Q each multiframe, repeating old pattern.
// - Unaligned but enabled: hunting bit in Q slots.
// - Aligned: send Q buffer bits three to zero.
// - Lose alignment: three bad, link leaves F6/F7, disable.
// - On loss clear aligned flag, set change flag.
// - After loss stop S capture and Q insertion.
// - Hunt only when enabled and link in F6/F7.
// - Three good multiframes set aligned and change flags.
// - Start S delivery at next multiframe after alignment.
module mfsq_top (
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic                  frame_strobe,
   input  wire mfsq_pkg::mfsq_frame_s rx_frame,
   input  wire logic            [2:0] line_state,
   input  wire logic                  mf_enable,
   input  wire logic                  mf_int_en,
   input  wire logic                  q_wr,
   input  wire logic            [4:0] q_wr_data,
   input  wire logic                  enh_wr,
   input  wire logic                  enh_wr_data,
   input  wire logic                  status_rd,
   output logic                       tx_fa,
   output logic                       mf_synced,
   output logic                       mf_first_word,
   output logic                       enh_mode,
   output logic                 [7:0] status_buf,
   output logic                       s_irq,
   output logic                       s_overrun
);
   mfsq_pkg::mfsq_sync_e  state_q;
   mfsq_pkg::mfsq_sword_s push_word;
   mfsq_pkg::mfsq_sword_s pop_word;
   logic [1:0] good_q;
   logic [1:0] bad_q;
   logic [4:0] frame_nxt;
   logic [2:0] slot;
   logic [1:0] group;
   logic       mf_done;
   logic       mf_valid;
   logic       link_ok;
   logic       fr_evt;
   logic       sync_gain;
   logic       sync_loss;
   logic       in_sync;
   logic       cap_on_q;
   logic       cap_now;
   logic [3:0] sh_q;
   logic       push;
   logic       push_ready;
   logic       pop_valid;
   logic       load;
   logic       avail_q;
   logic [4:0] sword_q;
   logic       first_q;
   logic       irq_q;
   logic       enh_q;
   logic       cos_q;
   logic [4:0] qbuf_q;
   logic [3:0] shadow_q;
   logic [3:0] q_cur;
   logic       q_xfer;
   logic       qempty_q;
   logic       tx_q;
   logic       hunt_bit;

   // Alignment is sought only with multiframing on and the link active.
   assign link_ok = mf_enable && ((line_state == mfsq_pkg::LINE_F6) ||
                                  (line_state == mfsq_pkg::LINE_F7));

   mfsq_frame_track u_track (
      .clk       (core_clk),
      .rstn      (resetn),
      .hunt_en   (link_ok),
      .strobe    (frame_strobe),
      .rx        (rx_frame),
      .frame_nxt (frame_nxt),
      .mf_done   (mf_done),
      .mf_valid  (mf_valid)
   );

   assign slot   = mfsq_pkg::mfsq_slot(frame_nxt);
   assign group  = mfsq_pkg::mfsq_group(frame_nxt);
   assign fr_evt = frame_strobe && mf_done;

   // Gain after three good multiframes, loss after three bad or link drop.
   assign sync_gain = link_ok && (state_q == mfsq_pkg::MFSQ_HUNT) && fr_evt && mf_valid &&
                      (good_q == mfsq_pkg::GOOD_LAST);
   assign sync_loss = (state_q == mfsq_pkg::MFSQ_SYNC) &&
                      (!link_ok || (fr_evt && !mf_valid && (bad_q == mfsq_pkg::BAD_LAST)));
   assign in_sync   = (state_q == mfsq_pkg::MFSQ_SYNC) && !sync_loss;
   assign mf_synced = (state_q == mfsq_pkg::MFSQ_SYNC);

   // Alignment state machine with its good and bad run counters.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= mfsq_pkg::MFSQ_HUNT;
         good_q  <= 2'h0;
         bad_q   <= 2'h0;
      end else if (!link_ok) begin
         state_q <= mfsq_pkg::MFSQ_HUNT;
         good_q  <= 2'h0;
         bad_q   <= 2'h0;
      end else if (fr_evt) begin
         unique case (state_q)
            mfsq_pkg::MFSQ_HUNT: begin
               if (sync_gain) begin
                  state_q <= mfsq_pkg::MFSQ_SYNC;
                  good_q  <= 2'h0;
               end else if (mf_valid) begin
                  good_q <= good_q + 2'h1;
               end else begin
                  good_q <= 2'h0;
               end
            end
            mfsq_pkg::MFSQ_SYNC: begin
               if (sync_loss) begin
                  state_q <= mfsq_pkg::MFSQ_HUNT;
                  bad_q   <= 2'h0;
               end else if (!mf_valid) begin
                  bad_q <= bad_q + 2'h1;
               end else begin
                  bad_q <= 2'h0;
               end
            end
         endcase
      end
   end

   // Capture waits for the first frame one seen while already aligned.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cap_on_q <= 1'b0;
      end else if (!in_sync) begin
         cap_on_q <= 1'b0;
      end else if (frame_strobe && (frame_nxt == mfsq_pkg::FRAME_FIRST)) begin
         cap_on_q <= 1'b1;
      end
   end

   assign cap_now = in_sync && frame_strobe && (frame_nxt != mfsq_pkg::FRAME_NONE) &&
                    (cap_on_q || (frame_nxt == mfsq_pkg::FRAME_FIRST));

   // One S bit per frame; the earliest bit of a group lands in the MSB.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sh_q <= 4'h0;
      end else if (cap_now) begin
         sh_q <= {sh_q[2:0], rx_frame.s};
      end
   end

   // A word is pushed at the last frame of each five-frame group.
   assign push            = cap_now && (slot == mfsq_pkg::SLOT_LAST);
   assign push_word.word  = {sh_q, rx_frame.s};
   assign push_word.first = (group == mfsq_pkg::GROUP_FIRST);
   // The line cannot be stalled, so a word meeting a full FIFO is dropped and flagged.
   assign s_overrun       = push && !push_ready;

   mfsq_fifo #(
      .WIDTH (mfsq_pkg::SWORD_W),
      .DEPTH (mfsq_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk       (core_clk),
      .rstn      (resetn),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   (push_word),
      .out_valid (pop_valid),
      .out_ready (!avail_q),
      .out_data  (pop_word)
   );

   // The status buffer takes a new word only once the previous one was read.
   assign load = pop_valid && !avail_q;

   // Available flag: the load wins over a read in the same cycle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         avail_q <= 1'b0;
      end else if (load) begin
         avail_q <= 1'b1;
      end else if (status_rd) begin
         avail_q <= 1'b0;
      end
   end

   // Word, position marker and interrupt worthiness are latched at load.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sword_q <= mfsq_pkg::SWORD_RST;
         first_q <= 1'b0;
         irq_q   <= 1'b0;
      end else if (load) begin
         sword_q <= pop_word.word;
         first_q <= pop_word.first;
         irq_q   <= !enh_q || (pop_word.word != 5'h00);
      end
   end

   // Enhanced mode clears itself on a non-zero word while interrupts are on, so later idle words pass.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         enh_q <= 1'b0;
      end else if (enh_wr) begin
         enh_q <= enh_wr_data;
      end else if (load && mf_int_en && (pop_word.word != 5'h00)) begin
         enh_q <= 1'b0;
      end
   end

   // Change of alignment state: an event wins over the clearing read.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cos_q <= 1'b0;
      end else if (sync_gain || sync_loss) begin
         cos_q <= 1'b1;
      end else if (status_rd) begin
         cos_q <= 1'b0;
      end
   end

   // Software Q buffer; bit four is the hunting value.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         qbuf_q <= mfsq_pkg::QBUF_RST;
      end else if (q_wr) begin
         qbuf_q <= q_wr_data;
      end
   end

   // Q data moves to the line at every aligned frame one.
   assign q_xfer   = in_sync && frame_strobe && (frame_nxt == mfsq_pkg::FRAME_FIRST);
   assign q_cur    = q_xfer ? qbuf_q[3:0] : shadow_q;
   assign hunt_bit = qbuf_q[mfsq_pkg::QB_HUNT];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         shadow_q <= 4'h0;
      end else if (q_xfer) begin
         shadow_q <= qbuf_q[3:0];
      end
   end

   // Q-empty flag: a transfer wins over the clearing read.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         qempty_q <= mfsq_pkg::QEMPTY_RST;
      end else if (q_xfer) begin
         qempty_q <= 1'b1;
      end else if (status_rd) begin
         qempty_q <= 1'b0;
      end
   end

   // Transmitted FA bit, updated once per received frame.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_q <= 1'b0;
      end else if (frame_strobe) begin
         if (!mf_enable) begin
            tx_q <= 1'b0;
         end else if (in_sync && (frame_nxt != mfsq_pkg::FRAME_NONE)) begin
            if (slot == mfsq_pkg::SLOT_FIRST) begin
               tx_q <= q_cur[mfsq_pkg::GROUP_LAST - group];
            end else begin
               tx_q <= 1'b0;
            end
         end else begin
            // Without alignment the received FA marks the Q positions.
            tx_q <= rx_frame.fa && hunt_bit;
         end
      end
   end

   assign tx_fa         = tx_q;
   assign mf_first_word = first_q;
   assign enh_mode      = enh_q;
   assign status_buf    = {cos_q, qempty_q, avail_q, sword_q};
   assign s_irq         = avail_q && mf_int_en && irq_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // A loaded word shows as available with its data on the next cycle.
   a_avail_load: assert property (load |=> avail_q && (sword_q == $past(pop_word.word)))
      else $error("available flag or word missing after load");

   // An all-zero word in enhanced mode never interrupts.
   a_enh_zero: assert property (load && enh_q && (pop_word.word == 5'h00) |=> !s_irq)
      else $error("zero word raised interrupt in enhanced mode");

   // A non-zero word with interrupts on drops enhanced mode.
   a_enh_clear: assert property (load && mf_int_en && !enh_wr && (pop_word.word != 5'h00) |=> !enh_mode)
      else $error("enhanced mode not cleared by non-zero word");

   // Reading the status clears Q-empty unless a transfer coincides.
   a_qempty_read: assert property (status_rd && !q_xfer |=> !status_buf[mfsq_pkg::ST_QEMPTY])
      else $error("Q-empty not cleared by read");

   // Aligned non-Q frames send zero.
   a_tx_zero: assert property (frame_strobe && in_sync && mf_enable && (frame_nxt != 5'h00) &&
                               (slot != mfsq_pkg::SLOT_FIRST) |=> !tx_fa)
      else $error("non-Q frame sent a one");

   // Aligned Q frames send the matching buffered bit.
   a_tx_qbit: assert property (frame_strobe && in_sync && mf_enable && (frame_nxt != 5'h00) &&
                               (slot == mfsq_pkg::SLOT_FIRST) |=> tx_fa == $past(q_cur[mfsq_pkg::GROUP_LAST - group]))
      else $error("wrong Q bit sent");

   // Hunting Q positions carry the hunting bit.
   a_hunt_qbit: assert property (frame_strobe && mf_enable && !in_sync && rx_frame.fa |=> tx_fa == $past(hunt_bit))
      else $error("hunting bit not sent");

   // Link leaving F6 and F7 ends alignment and flags the change.
   a_loss_link: assert property (mf_synced && !link_ok |=> !mf_synced && status_buf[mfsq_pkg::ST_COS])
      else $error("alignment kept after link drop");

   // Gaining alignment sets both flags.
   a_sync_gain: assert property (sync_gain |=> mf_synced && status_buf[mfsq_pkg::ST_COS])
      else $error("alignment gain not flagged");

   // Nothing is captured while not aligned.
   a_no_capture: assert property (!mf_synced |-> !push ##1 !push)
      else $error("S word captured without alignment");

   // Words pushed for group one carry the first marker.
   a_first_mark: assert property (push |-> push_word.first == (frame_nxt == 5'h05))
      else $error("first-word marker misplaced");

   c_sync_gain: cover property (sync_gain);
   c_sync_loss: cover property (sync_loss && link_ok);
   c_word_load: cover property (load && pop_word.first ##1 s_irq);
   c_overrun:   cover property (s_overrun);
endmodule : mfsq_top
`default_nettype wire

// ---- dv/mfsq_nt_model.sv ----
// Network terminator model that sends twenty-frame multiframes of FA, M and S bits.
`timescale 1ns/100ps
`default_nettype none
module mfsq_nt_model (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             run,
   input  wire logic             corrupt,
   input  wire logic      [19:0] s_pattern,
   output logic                  strobe,
   output mfsq_pkg::mfsq_frame_s rx,
   output logic           [4:0]  frame_no
);
   logic [2:0] tick_q;
   logic [4:0] nxt;
   // Frame numbers wrap from twenty back to one.
   assign nxt = (frame_no == 5'h14) ? 5'h01 : frame_no + 5'h01;
   // One frame every eight cycles; between frames the bits toggle so stale values never look valid.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_q   <= 3'h0;
         strobe   <= 1'b0;
         rx       <= '0;
         frame_no <= 5'h14;
      end else begin
         tick_q <= tick_q + 3'h1;
         strobe <= run && (tick_q == 3'h7);
         if (run && (tick_q == 3'h7)) begin
            frame_no <= nxt;
            rx.fa    <= (nxt == 5'h01 || nxt == 5'h06 || nxt == 5'h0b || nxt == 5'h10) ^ (corrupt && nxt == 5'h06);
            rx.m     <= (nxt == 5'h01);
            rx.s     <= s_pattern[5'h14 - nxt];
         end else begin
            rx <= ~rx;
         end
      end
   end
endmodule : mfsq_nt_model
`default_nettype wire

// ---- dv/mfsq_tb_top.sv ----
// Self-checking bench of the multiframe S and Q channel block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
`define WAIT_FOR(cond, n) begin k = 0; while (!(cond) && k < n) begin @(posedge core_clk); #1; k++; end end
module mfsq_tb_top;
   typedef struct packed {
      logic       enh;
      logic [4:0] word;
      logic [2:0] first_irq_enh;
   } mfsq_row_s;
   // Each row: enhanced mode written, word expected, then first marker, interrupt and enhanced readback.
   mfsq_row_s rows [8] = '{{1'b0, 5'h15, 3'h6}, {1'b0, 5'h00, 3'h2}, {1'b0, 5'h1f, 3'h2}, {1'b0, 5'h01, 3'h2},
                           {1'b1, 5'h15, 3'h6}, {1'b1, 5'h00, 3'h1}, {1'b1, 5'h1f, 3'h2}, {1'b0, 5'h01, 3'h2}};
   logic                  core_clk = 1'b0, resetn = 1'b0, run = 1'b0, corrupt = 1'b0;
   logic                  mf_enable = 1'b0, mf_int_en = 1'b0, q_wr = 1'b0, enh_wr = 1'b0;
   logic                  enh_wr_data = 1'b0, status_rd = 1'b0;
   logic            [2:0] line_state = 3'h0;
   logic            [4:0] q_wr_data = 5'h00, frame_no, f;
   logic                  frame_strobe, tx_fa, mf_synced, mf_first_word, enh_mode, s_irq, s_overrun;
   logic            [7:0] status_buf;
   mfsq_pkg::mfsq_frame_s rx_frame;
   int                    errors = 0, n_checks = 0, cycles = 0, k, i, n_read, ovr = 0;

   mfsq_nt_model i_nt (.clk(core_clk), .rstn(resetn), .run(run), .corrupt(corrupt),
      .s_pattern({5'h15, 5'h00, 5'h1f, 5'h01}), .strobe(frame_strobe), .rx(rx_frame), .frame_no(frame_no));
   mfsq_top i_dut (.core_clk(core_clk), .resetn(resetn), .frame_strobe(frame_strobe), .rx_frame(rx_frame),
      .line_state(line_state), .mf_enable(mf_enable), .mf_int_en(mf_int_en), .q_wr(q_wr), .q_wr_data(q_wr_data),
      .enh_wr(enh_wr), .enh_wr_data(enh_wr_data), .status_rd(status_rd), .tx_fa(tx_fa), .mf_synced(mf_synced),
      .mf_first_word(mf_first_word), .enh_mode(enh_mode), .status_buf(status_buf), .s_irq(s_irq),
      .s_overrun(s_overrun));

   // A 40 ns clock.
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   // The sequence needs about three thousand cycles, so this ceiling only trips on a hang.
   always @(posedge core_clk) begin
      cycles++;
      ovr = ovr + int'(s_overrun === 1'b1);
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   // One-cycle strobe: 0 writes the Q buffer, 1 the enhanced bit, 2 reads status.
   task automatic poke(input int sel, input logic [4:0] v);
      @(posedge core_clk);
      q_wr        <= (sel == 0);
      enh_wr      <= (sel == 1);
      status_rd   <= (sel == 2);
      q_wr_data   <= v;
      enh_wr_data <= v[0];
      @(posedge core_clk);
      q_wr      <= 1'b0;
      enh_wr    <= 1'b0;
      status_rd <= 1'b0;
      #1;
   endtask : poke

   // Returns one cycle after the next frame strobe, when the sent bit has settled.
   task automatic next_frame();
      do begin
         @(posedge core_clk);
         #1;
      end while (frame_strobe !== 1'b1);
      f = frame_no;
      @(posedge core_clk);
      #1;
   endtask : next_frame

   function automatic logic exp_q(input logic [4:0] fr, input logic [4:0] q);
      case (fr)
         5'h01: return q[3];
         5'h06: return q[2];
         5'h0b: return q[1];
         5'h10: return q[0];
         default: return 1'b0;
      endcase
   endfunction : exp_q

   // Main sequence.
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      #1;
      `CHK(status_buf, 8'h40)
      `CHK({mf_synced, tx_fa, s_irq}, 3'h0)
      $display("test reset done");
      @(posedge core_clk);
      mf_enable <= 1'b1;
      mf_int_en <= 1'b1;
      line_state <= mfsq_pkg::LINE_F6;
      run       <= 1'b1;
      poke(0, 5'h10);
      do next_frame(); while (f != 5'h06);
      `CHK(tx_fa, 1'b1)
      `WAIT_FOR(mf_synced === 1'b1, 2000)
      `CHK({mf_synced, status_buf[7]}, 2'h3)
      poke(2, 5'h00);
      `CHK(status_buf[7:5], 3'h0)
      $display("test alignment done");
      for (i = 0; i < 8; i++) begin
         poke(1, {4'h0, rows[i].enh});
         `WAIT_FOR(status_buf[5] === 1'b1, 400)
         `CHK(status_buf[5], 1'b1)
         `CHK(status_buf[4:0], rows[i].word)
         `CHK({mf_first_word, s_irq}, rows[i].first_irq_enh[2:1])
         poke(2, 5'h00);
         `CHK(enh_mode, rows[i].first_irq_enh[0])
      end
      $display("test s words done");
      do next_frame(); while (f != 5'h03);
      poke(2, 5'h00);
      `CHK(status_buf[6], 1'b0)
      poke(0, 5'h0a);
      do next_frame(); while (f != 5'h01);
      `CHK(status_buf[6], 1'b1)
      for (i = 0; i < 40; i++) begin
         if (i > 0) next_frame();
         `CHK(tx_fa, exp_q(f, 5'h0a))
      end
      $display("test q bits done");
      corrupt <= 1'b1;
      `WAIT_FOR(mf_synced === 1'b0, 700)
      `CHK({mf_synced, status_buf[7]}, 2'h1)
      do next_frame(); while (f != 5'h01);
      `CHK(tx_fa, 1'b0)
      `CHK(ovr > 0, 1'b1)
      n_read = 0;
      while (status_buf[5] === 1'b1 && n_read < 40) begin
         poke(2, 5'h00);
         n_read++;
         repeat (2) @(posedge core_clk);
         #1;
      end
      `CHK(n_read > 15 && status_buf[5] === 1'b0, 1'b1)
      corrupt <= 1'b0;
      `WAIT_FOR(mf_synced === 1'b1, 1000)
      @(posedge core_clk);
      line_state <= 3'h6;
      repeat (3) @(posedge core_clk);
      #1;
      `CHK(mf_synced, 1'b0)
      $display("test loss done");
      report_and_stop();
   end
endmodule : mfsq_tb_top
`default_nettype wire
